// [rtl/mac_pkg.sv]
// Overview of operation
// - dma mode with shift enabled shifts accumulator 1..4 bits per count code
// - shift enable shifts the 40-bit accumulator one bit, and gates dma multi-bit
// - direction bit picks every shift: 0 left, 1 right
// - after signed operations, sign differing from expected sign sets the flag
// - signed enable selects unsigned or two's complement multiply-accumulate
// - dma mode, b source 0 requests b fetch; 1 reuses held b
// - dma mode, a source 0 requests a fetch; 1 reuses held a
// - b post-increment adds one to b after each operation, both modes
// - a post-increment adds one to a after each operation, both modes
// - config register at sfr 0xC4, page 0xF, read/write, resets to zero
package mac_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] MAC_CFG1_ADDR  = 8'hC4;
  localparam logic [3:0] MAC_CFG1_PAGE  = 4'hF;
  localparam logic [7:0] MAC_CFG1_RESET = 8'h00;
  // ==========================================================
  // widths
  localparam int MAC_OPW = 16;
  localparam int MAC_ACCW = 40;
  localparam int MAC_ACC_MSB = 39;
  localparam logic [2:0] MAC_SHIFT_BASE = 3'h1;

  typedef struct packed {
    logic [1:0] multibit_shift_count;
    logic       expected_sign;
    logic       signed_arith_enable;
    logic       b_operand_reuse_sel;
    logic       b_post_increment;
    logic       a_operand_reuse_sel;
    logic       a_post_increment;
  } mac_cfg_t;

  typedef struct packed {
    logic acc_shift_enable;
    logic acc_shift_direction;
  } mac_shift_t;
endpackage

// [rtl/mac_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_shifter
  import mac_pkg::*;
(
  // control
  input  wire logic [2:0]          amount_i,
  input  wire logic                dir_right_i,
  // data
  input  wire logic [MAC_ACCW-1:0] acc_i,
  output logic      [MAC_ACCW-1:0] acc_o
);
  // ==========================================================
  // barrel shift; arithmetic right keeps sign of signed sums
  always_comb begin
    if (dir_right_i) begin
      acc_o = MAC_ACCW'($signed(acc_i) >>> amount_i);
    end else begin
      acc_o = acc_i << amount_i;
    end
  end
endmodule
`default_nettype wire

// [rtl/mac_operand_config.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_operand_config
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // sfr bus
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic [3:0]          sfr_page_i,
  input  wire logic                sfr_wr_i,
  input  wire logic [7:0]          sfr_wdata_i,
  output logic      [7:0]          sfr_rdata_o,
  // shift controls from neighbouring config register
  input  wire mac_shift_t          shift_ctl_i,
  // operation control
  input  wire logic                op_start_i,
  input  wire logic                dma_mode_i,
  input  wire logic [MAC_OPW-1:0]  a_load_i,
  input  wire logic                a_load_en_i,
  input  wire logic [MAC_OPW-1:0]  b_load_i,
  input  wire logic                b_load_en_i,
  input  wire logic                flag_clr_i,
  // dma fetch requests
  output logic                     a_fetch_req_o,
  output logic                     b_fetch_req_o,
  // datapath state
  output logic      [MAC_OPW-1:0]  a_o,
  output logic      [MAC_OPW-1:0]  b_o,
  output logic      [MAC_ACCW-1:0] acc_o,
  output logic                     sign_change_flag_o,
  output logic                     op_done_o
);
  // ==========================================================
  // config register
  mac_cfg_t             cfg_reg;
  logic                 sel;
  logic [MAC_OPW-1:0]   a_reg;
  logic [MAC_OPW-1:0]   b_reg;
  logic [MAC_ACCW-1:0]  acc_reg;
  logic [MAC_ACCW-1:0]  acc_next;
  logic [MAC_ACCW-1:0]  sum;
  logic [MAC_ACCW-1:0]  shifted;
  logic [MAC_ACCW-1:0]  prod_ext;
  logic [2:0]           amount;
  logic                 do_shift;
  logic                 flag_reg;
  logic                 signed_done_reg;
  logic                 done_reg;

  assign sel = (sfr_addr_i == MAC_CFG1_ADDR) && (sfr_page_i == MAC_CFG1_PAGE);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= mac_cfg_t'(MAC_CFG1_RESET);
    end else if (sel && sfr_wr_i) begin
      cfg_reg <= mac_cfg_t'(sfr_wdata_i);
    end
  end

  // read mux is combinational; bus samples it on the read cycle
  assign sfr_rdata_o = sel ? 8'(cfg_reg) : 8'h00;

  // ==========================================================
  // dma operand requests; cpu mode never fetches
  assign a_fetch_req_o = op_start_i && dma_mode_i && !cfg_reg.a_operand_reuse_sel;
  assign b_fetch_req_o = op_start_i && dma_mode_i && !cfg_reg.b_operand_reuse_sel;

  // ==========================================================
  // multiply and accumulate
  always_comb begin
    if (cfg_reg.signed_arith_enable) begin
      prod_ext = MAC_ACCW'($signed(a_reg) * $signed(b_reg));
    end else begin
      prod_ext = MAC_ACCW'(a_reg * b_reg);
    end
  end
  assign sum = acc_reg + prod_ext;

  // multi-bit only in dma mode; cpu mode gets a single bit
  assign do_shift = shift_ctl_i.acc_shift_enable;
  assign amount = dma_mode_i ? (3'(cfg_reg.multibit_shift_count) + MAC_SHIFT_BASE)
                             : MAC_SHIFT_BASE;

  mac_shifter u_shift (
    .amount_i    (amount),
    .dir_right_i (shift_ctl_i.acc_shift_direction),
    .acc_i       (sum),
    .acc_o       (shifted)
  );

  assign acc_next = do_shift ? shifted : sum;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
    end else if (op_start_i) begin
      acc_reg <= acc_next;
    end
  end

  // ==========================================================
  // operand registers; load wins over increment
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      a_reg <= '0;
    end else if (a_load_en_i) begin
      a_reg <= a_load_i;
    end else if (op_start_i && cfg_reg.a_post_increment) begin
      a_reg <= a_reg + MAC_OPW'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      b_reg <= '0;
    end else if (b_load_en_i) begin
      b_reg <= b_load_i;
    end else if (op_start_i && cfg_reg.b_post_increment) begin
      b_reg <= b_reg + MAC_OPW'(1);
    end
  end

  // ==========================================================
  // sign change flag; a set in the clear cycle wins
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      signed_done_reg <= 1'b0;
      done_reg        <= 1'b0;
    end else begin
      signed_done_reg <= op_start_i && cfg_reg.signed_arith_enable;
      done_reg        <= op_start_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
    end else if (signed_done_reg && (acc_reg[MAC_ACC_MSB] != cfg_reg.expected_sign)) begin
      flag_reg <= 1'b1;
    end else if (flag_clr_i) begin
      flag_reg <= 1'b0;
    end
  end

  assign a_o                = a_reg;
  assign b_o                = b_reg;
  assign acc_o              = acc_reg;
  assign sign_change_flag_o = flag_reg;
  assign op_done_o          = done_reg;

  // ==========================================================
  // checks
  cfg_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel && sfr_wr_i |=> 8'(cfg_reg) == $past(sfr_wdata_i))
    else $error("config write lost");
  a_fetch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && dma_mode_i && !cfg_reg.a_operand_reuse_sel |-> a_fetch_req_o)
    else $error("a fetch missing");
  b_fetch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !dma_mode_i |-> !b_fetch_req_o)
    else $error("b fetch in cpu mode");
  a_inc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && !a_load_en_i && cfg_reg.a_post_increment |=> a_reg == $past(a_reg) + 16'h0001)
    else $error("a not incremented");
  b_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !b_load_en_i && !(op_start_i && cfg_reg.b_post_increment) |=> $stable(b_reg))
    else $error("b changed");
  sign_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && cfg_reg.signed_arith_enable ##1
    (acc_reg[MAC_ACC_MSB] != cfg_reg.expected_sign) |=> flag_reg)
    else $error("sign change missed");
  unsigned_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !flag_reg && !signed_done_reg |=> !flag_reg)
    else $error("flag set without signed op");
  shift_amt_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && dma_mode_i && do_shift && !shift_ctl_i.acc_shift_direction
    |=> acc_reg == ($past(sum) << (3'($past(cfg_reg.multibit_shift_count)) + MAC_SHIFT_BASE)))
    else $error("shift amount wrong");
  no_shift_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && !do_shift |=> acc_reg == $past(sum))
    else $error("unexpected shift");
  shift_dir_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && do_shift && !shift_ctl_i.acc_shift_direction && !dma_mode_i
    |=> acc_reg == {$past(sum[MAC_ACCW-2:0]), 1'b0})
    else $error("left shift wrong");
  right_dir_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && do_shift && shift_ctl_i.acc_shift_direction && !dma_mode_i
    |=> acc_reg == MAC_ACCW'($signed($past(sum)) >>> MAC_SHIFT_BASE))
    else $error("right shift wrong");
  signed_mac_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && !do_shift && cfg_reg.signed_arith_enable
    |=> acc_reg == $past(acc_reg) + MAC_ACCW'($signed($past(a_reg)) * $signed($past(b_reg))))
    else $error("signed product wrong");
  cpu_a_fetch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !dma_mode_i |-> !a_fetch_req_o)
    else $error("a fetch in cpu mode");
  b_request_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && dma_mode_i && !cfg_reg.b_operand_reuse_sel |-> b_fetch_req_o)
    else $error("b fetch missing");
  b_inc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    op_start_i && !b_load_en_i && cfg_reg.b_post_increment |=> b_reg == $past(b_reg) + 16'h0001)
    else $error("b not incremented");
  a_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !a_load_en_i && !(op_start_i && cfg_reg.a_post_increment) |=> $stable(a_reg))
    else $error("a changed");
  flag_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    flag_clr_i && !signed_done_reg |=> !flag_reg)
    else $error("flag not cleared");
  cfg_reset_a: assert property (@(posedge core_clk_i)
    !rst_n_i |=> 8'(cfg_reg) == MAC_CFG1_RESET)
    else $error("config reset value wrong");

  // ==========================================================
  // coverage
  dma_op_c: cover property (@(posedge core_clk_i) op_start_i && dma_mode_i && do_shift);
  flag_c: cover property (@(posedge core_clk_i) !flag_reg ##1 flag_reg);
  reuse_c: cover property (@(posedge core_clk_i) op_start_i && dma_mode_i && !a_fetch_req_o);
  right_shift_c: cover property (@(posedge core_clk_i)
    op_start_i && do_shift && shift_ctl_i.acc_shift_direction);
  flag_clear_c: cover property (@(posedge core_clk_i) flag_reg ##1 !flag_reg);
endmodule
`default_nettype wire

// [test/mac_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_dma_model
  import mac_pkg::*;
#(
  // fetched words, arbitrary
  parameter logic [MAC_OPW-1:0] A_WORD = 16'h0002,
  parameter logic [MAC_OPW-1:0] B_WORD = 16'h0003
)(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // fetch requests
  input  wire logic               a_req_i,
  input  wire logic               b_req_i,
  // operand delivery
  output logic                    a_en_o,
  output logic                    b_en_o,
  output logic      [MAC_OPW-1:0] a_data_o,
  output logic      [MAC_OPW-1:0] b_data_o
);
  // ==========================================================
  // one-cycle fetch latency; released data bus shows inverse
  logic a_pend = 1'b0;
  logic b_pend = 1'b0;
  always @(posedge clk_i) begin
    a_pend <= rst_n_i & a_req_i;
    b_pend <= rst_n_i & b_req_i;
  end
  assign a_en_o   = a_pend;
  assign b_en_o   = b_pend;
  assign a_data_o = a_pend ? A_WORD : ~A_WORD;
  assign b_data_o = b_pend ? B_WORD : ~B_WORD;
endmodule
`default_nettype wire

// [test/mac_operand_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_operand_config_test
  import mac_pkg::*;
;
  // ==========================================================
  // stimulus and model state
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, op = 1'b0, dma = 1'b0, clr = 1'b0;
  logic ta_en = 1'b0, tb_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, cfg = 8'h00;
  logic [3:0] page = 4'h0;
  logic [MAC_OPW-1:0] ta = 16'h0000, tb = 16'h0000, ea, eb;
  mac_shift_t sh = 2'h0;
  logic signed [MAC_ACCW-1:0] eacc = 40'h0, sa, sb;
  logic ef = 1'b0;
  int errors = 0, checked = 0, cycles = 0;
  wire logic [7:0] rdata;
  wire logic afr, bfr, flag, done, da_en, db_en;
  wire logic [MAC_OPW-1:0] a_q, b_q, da, db;
  wire logic [MAC_ACCW-1:0] acc_q;

  mac_dma_model dma_u (.clk_i(clk), .rst_n_i(rst_n), .a_req_i(afr), .b_req_i(bfr),
    .a_en_o(da_en), .b_en_o(db_en), .a_data_o(da), .b_data_o(db));
  mac_operand_config dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr),
    .sfr_page_i(page), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .shift_ctl_i(sh), .op_start_i(op), .dma_mode_i(dma), .a_load_i(da_en ? da : ta),
    .a_load_en_i(ta_en | da_en), .b_load_i(db_en ? db : tb), .b_load_en_i(tb_en | db_en),
    .flag_clr_i(clr), .a_fetch_req_o(afr), .b_fetch_req_o(bfr), .a_o(a_q), .b_o(b_q),
    .acc_o(acc_q), .sign_change_flag_o(flag), .op_done_o(done));

  // ==========================================================
  // tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(negedge clk); addr = a; page = p; wdata = d; wr = 1'b1;
    @(negedge clk); wr = 1'b0;
    if (a == MAC_CFG1_ADDR && p == MAC_CFG1_PAGE) cfg = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
    @(negedge clk); addr = a; page = p;
    #1 check(rdata, e);
  endtask
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    @(negedge clk); ta = a; tb = b; ta_en = 1'b1; tb_en = 1'b1;
    @(negedge clk); ta_en = 1'b0; tb_en = 1'b0; ea = a; eb = b;
  endtask
  task automatic do_op(input logic d);
    int amt;
    @(negedge clk); dma = d; op = 1'b1;
    #1 check(afr, d & ~cfg[1]);
    check(bfr, d & ~cfg[3]);
    sa = $signed(ea);
    sb = $signed(eb);
    eacc = eacc + (cfg[4] ? sa * sb : {24'h0, ea} * {24'h0, eb});
    amt = d ? int'(cfg[7:6]) + 1 : 1;
    if (sh.acc_shift_enable) eacc = sh.acc_shift_direction ? eacc >>> amt : eacc << amt;
    if (cfg[4] && eacc[39] !== cfg[5]) ef = 1'b1;
    ea = (d && !cfg[1]) ? dma_u.A_WORD : ea + 16'(cfg[0]);
    eb = (d && !cfg[3]) ? dma_u.B_WORD : eb + 16'(cfg[2]);
    @(negedge clk); op = 1'b0;
    check(done, 1'b1);
    @(negedge clk);
    check(a_q, ea);
    check(b_q, eb);
    check(acc_q, eacc);
    check(flag, ef);
    check(done, 1'b0);
  endtask
  task automatic summarize();
    $display("mismatches %0d of %0d compares", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rd(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h00);
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'hFF);
    rd(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'hFF);
    wr_reg(MAC_CFG1_ADDR, 4'hE, 8'h00);
    wr_reg(8'hC5, MAC_CFG1_PAGE, 8'h00);
    rd(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'hFF);
    rd(8'hC5, MAC_CFG1_PAGE, 8'h00);
    // cpu mode ignores source bits, so no fetch here
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h05);
    load(16'h0003, 16'h0005);
    do_op(1'b0);
    do_op(1'b0);
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h00);
    do_op(1'b0);
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h10);
    load(16'h8000, 16'h0100);
    do_op(1'b0);
    @(negedge clk); clr = 1'b1;
    @(negedge clk); clr = 1'b0; ef = 1'b0;
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h30);
    do_op(1'b0);
    // unsigned with negative accumulator must not flag
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h0A);
    load(16'h0007, 16'h0009);
    do_op(1'b1);
    wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, 8'h00);
    do_op(1'b1);
    sh.acc_shift_enable = 1'b1;
    for (int dir = 0; dir < 2; dir++) begin
      sh.acc_shift_direction = dir[0];
      for (int c = 0; c < 4; c++) begin
        wr_reg(MAC_CFG1_ADDR, MAC_CFG1_PAGE, {c[1:0], 6'h15});
        do_op(1'b1);
      end
      do_op(1'b0);
    end
    summarize();
  end
endmodule
`default_nettype wire
